// ---- hw/dpc_consts.svh ----
// named widths, timings and counts for the dual-port RAM port controller
// assumes inclusion by bare name from the package and the controller
`ifndef DPC_CONSTS_SVH
`define DPC_CONSTS_SVH

`define DPC_ADDR_W      11
`define DPC_DATA_W      8
`define DPC_CLK_NS      8
// longest flag access or release after address or select change
`define DPC_T_FLAG_NS   20
`define DPC_T_ACC_NS    20
`define DPC_T_WP_NS     15
`define DPC_T_STALLED_WRITE_HOLD_NS 12
`define DPC_T_BDD_NS    25
`define DPC_SYNC_STAGES 2
`define DPC_CNT_W       4
`define DPC_CNT_ONE     4'h1
`define DPC_CNT_ZERO    4'h0
`define DPC_CNT_MAX     4'hF

`endif

// ---- hw/dpc_host.sv ----
// controller driving one port of an asynchronous 2K x 8 dual-port RAM
// assumes the RAM port pins and conflict flag are wired to the board;
// flag and data bus arrive asynchronously and are synchronised here
//
// Overview of operation
// R1: deselected port floats data, ignores strobes, stands by.
// R2: selected port with write strobe low stores its data.
// R3: selected, strobe high, output enable low drives addressed word out.
// R4: flag goes low only when both ports select one address together.
// R5: arbitration looks at select and address only, not read or write.
// R6: port settling first proceeds; later port gets the flag.
// R7: lead of 5 ns guarantees winner; otherwise exactly one side flagged.
// R8: both flags are never low at once.
// R9: writes of the flagged port are discarded inside the RAM.
// R10: master flags are open drain, pulled up externally.
// R11: slave takes flags as write inhibit inputs.
// R12: a write while flagged leaves memory unchanged.
// R13: reads while flagged are invalid; wait release plus data delay.
// R14: flag changes within 20 ns of address or select change.
// R15: stalled write keeps strobe low 12 ns after flag release.
// R16: slave inhibit must be valid by start of write strobe.
// R17: written data reaches opposite port within 50 ns.
// R18: read valid after release follows the larger of three delays.
// R19: address and select settle until flag is known before writing.
// R20: one master decides; slaves in width share its flags.
// R21: flagged host stalls until the other side finishes.
// R22: 11-bit address into 2048 shared bytes, 8-bit data bus.
`timescale 1ns/100ps
`include "dpc_consts.svh"

module dpc_host (
	input  wire logic                   i_clk,
	input  wire logic                   i_rst,
	input  wire logic                   i_req_valid,
	input  wire dpc_pkg::dpc_req_t      i_req,
	output logic                        o_req_ready,
	output logic                        o_done,
	output logic [`DPC_DATA_W-1:0]      o_rdata,
	output logic                        o_conflict,
	input  wire logic                   i_conflict_flag_n,
	input  wire logic [`DPC_DATA_W-1:0] i_data,
	output dpc_pkg::dpc_pins_t          o_pins
);

	localparam int CLK  = `DPC_CLK_NS;
	localparam int SYNC = `DPC_SYNC_STAGES;
	localparam int SETTLE_C = (`DPC_T_FLAG_NS + CLK - 1) / CLK + SYNC;
	localparam int ACC_C    = (`DPC_T_ACC_NS + CLK - 1) / CLK + SYNC;
	localparam int WP_C     = (`DPC_T_WP_NS + CLK - 1) / CLK;
	localparam int HOLD_C   = (`DPC_T_STALLED_WRITE_HOLD_NS + CLK - 1) / CLK;
	localparam int BDD_C    = (`DPC_T_BDD_NS + CLK - 1) / CLK + SYNC;

	dpc_pkg::dpc_state_t    state;
	dpc_pkg::dpc_state_t    next_state;
	dpc_pkg::dpc_req_t      req_q;
	dpc_pkg::dpc_req_t      cur_req;
	logic [`DPC_CNT_W-1:0]  cnt;
	logic [`DPC_CNT_W-1:0]  rel_age;
	logic [`DPC_CNT_W-1:0]  sel_age;
	logic                   flag_m;
	logic                   flag_s;
	logic [`DPC_DATA_W-1:0] data_m;
	logic [`DPC_DATA_W-1:0] data_s;
	logic                   stalled;
	logic                   last_tick;

	// R20 one flag source
	// two-stage synchronisers for flag and read data
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			flag_m <= 1'b1;
			flag_s <= 1'b1;
			data_m <= '0;
			data_s <= '0;
		end else begin
			flag_m <= i_conflict_flag_n;
			flag_s <= flag_m;
			data_m <= i_data;
			data_s <= data_m;
		end
	end

	assign last_tick = (cnt <= `DPC_CNT_ONE);

	always_comb begin
		next_state = state;
		case (state)
			dpc_pkg::dpc_st_idle: begin
				if (i_req_valid && o_req_ready) begin
					next_state = dpc_pkg::dpc_st_settle;
				end
			end
			// R16 R19 settle before strobe
			dpc_pkg::dpc_st_settle: begin
				if (last_tick) begin
					if (!flag_s) begin
						next_state = dpc_pkg::dpc_st_stall;
					end else if (req_q.write) begin
						next_state = dpc_pkg::dpc_st_write;
					end else begin
						next_state = dpc_pkg::dpc_st_read;
					end
				end
			end
			// R21 stall until release
			dpc_pkg::dpc_st_stall: begin
				if (flag_s) begin
					next_state = req_q.write ? dpc_pkg::dpc_st_write : dpc_pkg::dpc_st_read;
				end
			end
			dpc_pkg::dpc_st_write: begin
				if (flag_s && last_tick) begin
					next_state = dpc_pkg::dpc_st_end;
				end
			end
			dpc_pkg::dpc_st_read: begin
				if (!flag_s) begin
					next_state = dpc_pkg::dpc_st_stall;
				end else if (last_tick) begin
					next_state = dpc_pkg::dpc_st_end;
				end
			end
			dpc_pkg::dpc_st_end: begin
				next_state = dpc_pkg::dpc_st_idle;
			end
			default: begin
				next_state = dpc_pkg::dpc_st_idle;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state <= dpc_pkg::dpc_st_idle;
		end else begin
			state <= next_state;
		end
	end

	// request capture; address held for whole access
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			req_q <= '0;
		end else if (o_req_ready && i_req_valid) begin
			req_q <= i_req;
		end
	end

	// live request while idle, so pins launch at the take edge
	assign cur_req = (state == dpc_pkg::dpc_st_idle) ? i_req : req_q;

	// phase counter
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt <= `DPC_CNT_ZERO;
		end else begin
			case (next_state)
				dpc_pkg::dpc_st_settle: begin
					// R14 wait worst flag delay
					cnt <= (state == dpc_pkg::dpc_st_idle) ? `DPC_CNT_W'(SETTLE_C) : cnt - 1'b1;
				end
				dpc_pkg::dpc_st_write: begin
					if (state != dpc_pkg::dpc_st_write) begin
						cnt <= `DPC_CNT_W'(WP_C > HOLD_C ? WP_C : HOLD_C);
					end else if (!flag_s) begin
						// R15 hold strobe after release
						cnt <= `DPC_CNT_W'(HOLD_C);
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				dpc_pkg::dpc_st_read: begin
					if (state == dpc_pkg::dpc_st_settle) begin
						cnt <= `DPC_CNT_W'(ACC_C);
					end else if (state == dpc_pkg::dpc_st_stall) begin
						// R13 data valid after release
						cnt <= `DPC_CNT_W'(BDD_C);
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				default: begin
					cnt <= `DPC_CNT_ZERO;
				end
			endcase
		end
	end

	// conflict seen during this access
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			stalled <= 1'b0;
		end else if (state == dpc_pkg::dpc_st_idle) begin
			stalled <= 1'b0;
		end else if (state != dpc_pkg::dpc_st_settle && !flag_s) begin
			stalled <= 1'b1;
		end else if (state == dpc_pkg::dpc_st_settle && last_tick && !flag_s) begin
			stalled <= 1'b1;
		end
	end

	// pins registered from next state
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_pins       <= '0;
			o_pins.sel_n <= 1'b1;
			o_pins.oe_n  <= 1'b1;
			o_pins.we_n  <= 1'b1;
		end else begin
			// R1 deselect when idle
			o_pins.sel_n <= (next_state == dpc_pkg::dpc_st_idle) ||
			                (next_state == dpc_pkg::dpc_st_end);
			// R3 output enable only for reads
			o_pins.oe_n  <= cur_req.write || (next_state == dpc_pkg::dpc_st_idle) ||
			                (next_state == dpc_pkg::dpc_st_end);
			// R2 strobe only after flag known clear
			o_pins.we_n  <= (next_state != dpc_pkg::dpc_st_write);
			// R22 address and data width
			o_pins.addr  <= (next_state == dpc_pkg::dpc_st_idle) ? o_pins.addr : cur_req.addr;
			o_pins.data  <= cur_req.wdata;
			o_pins.data_oe <= cur_req.write && (next_state == dpc_pkg::dpc_st_write);
		end
	end

	// answer side
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_done      <= 1'b0;
			o_rdata     <= '0;
			o_conflict  <= 1'b0;
			o_req_ready <= 1'b0;
		end else begin
			o_done      <= (next_state == dpc_pkg::dpc_st_end);
			o_req_ready <= (next_state == dpc_pkg::dpc_st_idle);
			o_conflict  <= (next_state == dpc_pkg::dpc_st_stall) &&
			               (state != dpc_pkg::dpc_st_stall);
			if (state == dpc_pkg::dpc_st_read && next_state == dpc_pkg::dpc_st_end) begin
				o_rdata <= data_s;
			end
		end
	end

	// helper ages for checks
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rel_age <= `DPC_CNT_ZERO;
			sel_age <= `DPC_CNT_ZERO;
		end else begin
			rel_age <= !flag_s ? `DPC_CNT_ZERO :
			           (rel_age == `DPC_CNT_MAX ? rel_age : rel_age + 1'b1);
			sel_age <= o_pins.sel_n ? `DPC_CNT_ZERO :
			           (sel_age == `DPC_CNT_MAX ? sel_age : sel_age + 1'b1);
		end
	end

	a_idle_no_strobe: assert property (@(posedge i_clk) disable iff (i_rst) // R1
		o_pins.sel_n |-> (o_pins.we_n && o_pins.oe_n && !o_pins.data_oe))
		else $error("strobe active while deselected");

	a_read_no_drive: assert property (@(posedge i_clk) disable iff (i_rst) // R3
		!o_pins.oe_n |-> !o_pins.data_oe && o_pins.we_n)
		else $error("bus driven during read");

	a_addr_held_sel: assert property (@(posedge i_clk) disable iff (i_rst) // R19
		(!o_pins.sel_n && $past(!o_pins.sel_n)) |-> $stable(o_pins.addr))
		else $error("address moved while selected");

	a_write_after_settle: assert property (@(posedge i_clk) disable iff (i_rst) // R19
		$fell(o_pins.we_n) |-> sel_age >= `DPC_CNT_W'(SETTLE_C))
		else $error("write strobe before flag settled");

	a_hold_after_rel: assert property (@(posedge i_clk) disable iff (i_rst) // R15
		($rose(o_pins.we_n) && stalled) |-> rel_age >= `DPC_CNT_W'(HOLD_C))
		else $error("stalled write released too early");

	a_stall_waits: assert property (@(posedge i_clk) disable iff (i_rst) // R21
		(state == dpc_pkg::dpc_st_stall && !flag_s) |=>
			(state == dpc_pkg::dpc_st_stall && o_pins.we_n && !o_done))
		else $error("stall left while flagged");

	a_read_after_bdd: assert property (@(posedge i_clk) disable iff (i_rst) // R13
		(o_done && !req_q.write && stalled) |-> rel_age >= `DPC_CNT_W'(BDD_C) - `DPC_CNT_ONE)
		else $error("read data taken before valid");

	a_done_once: assert property (@(posedge i_clk) disable iff (i_rst) // R21
		o_done |=> !o_done && o_req_ready)
		else $error("done not a single cycle");

endmodule

// ---- hw/dpc_pkg.sv ----
// types shared by the dual-port RAM port controller
// assumes dpc_consts.svh is reachable by bare name
`include "dpc_consts.svh"

package dpc_pkg;

	typedef enum logic [2:0] {
		dpc_st_idle,
		dpc_st_settle,
		dpc_st_stall,
		dpc_st_write,
		dpc_st_read,
		dpc_st_end
	} dpc_state_t;

	typedef struct packed {
		logic                   write;
		logic [`DPC_ADDR_W-1:0] addr;
		logic [`DPC_DATA_W-1:0] wdata;
	} dpc_req_t;

	typedef struct packed {
		logic                   sel_n;
		logic                   oe_n;
		logic                   we_n;
		logic [`DPC_ADDR_W-1:0] addr;
		logic [`DPC_DATA_W-1:0] data;
		logic                   data_oe;
	} dpc_pins_t;

endpackage

// ---- testbench/dpc_host_tb_top.sv ----
// self-checking bench for the dual-port RAM port controller
// assumes dpc_pkg and dpc_ram_model are compiled before it
`timescale 1ns/100ps

module dpc_host_tb_top;
	logic               i_clk;
	logic               i_rst;
	logic               i_req_valid;
	dpc_pkg::dpc_req_t  i_req;
	logic               o_req_ready;
	logic               o_done;
	logic               o_conflict;
	logic [7:0]         o_rdata;
	logic [7:0]         ram_data;
	logic               flag_l_n;
	logic               flag_r_n;
	dpc_pkg::dpc_pins_t o_pins;
	logic               r_sel_n;
	logic               r_we_n;
	logic [10:0]        r_addr;
	logic [7:0]         r_data;
	int                 n_fail;
	int                 samples_checked;
	int                 cyc;
	int                 n_conf;

	dpc_host dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_req_valid(i_req_valid), .i_req(i_req),
		.o_req_ready(o_req_ready), .o_done(o_done), .o_rdata(o_rdata),
		.o_conflict(o_conflict), .i_conflict_flag_n(flag_l_n), .i_data(ram_data),
		.o_pins(o_pins));
	dpc_ram_model ram_u (.i_l_pins(o_pins), .i_r_sel_n(r_sel_n), .i_r_we_n(r_we_n),
		.i_r_addr(r_addr), .i_r_data(r_data), .o_l_data(ram_data), .o_l_flag_n(flag_l_n),
		.o_r_flag_n(flag_r_n));

	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	task automatic stop_test();
		if (n_fail == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic right(input logic s, input logic w, input logic [10:0] a, input logic [7:0] d);
		r_sel_n = s;
		r_we_n = w;
		r_addr = a;
		r_data = d;
	endtask

	task automatic xfer(input logic w, input logic [10:0] a, input logic [7:0] d);
		int n;
		n = 0;
		i_req_valid = 1'b1;
		i_req = '{write: w, addr: a, wdata: d};
		while (o_req_ready !== 1'b1) begin
			@(posedge i_clk);
			#1;
		end
		@(posedge i_clk);
		#1;
		i_req_valid = 1'b0;
		while (o_done !== 1'b1 && n < 200) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		check("done", 16'h1, {15'h0, o_done});
	endtask

	task automatic t_rw();
		logic [10:0] a;
		for (int i = 0; i < 3; i++) begin
			a = (i == 0) ? 11'h000 : (i == 1) ? 11'h7FF : 11'h2AA;
			xfer(1'b1, a, a[7:0] ^ 8'h5C);
			check("mem", {8'h00, a[7:0] ^ 8'h5C}, {8'h00, ram_u.mem[a]});
			xfer(1'b0, a, 8'h00);
			check("rdata", {8'h00, a[7:0] ^ 8'h5C}, {8'h00, o_rdata});
			check("sel_n", 16'h1, {15'h0, o_pins.sel_n});
		end
	endtask

	task automatic t_conflict(input logic w);
		xfer(1'b1, 11'h00C, 8'h11);
		right(1'b0, w, 11'h00C, 8'hC3);
		n_conf = 0;
		fork
			xfer(w, 11'h00C, 8'h3C);
			begin
				repeat (30) @(posedge i_clk);
				#1;
				check("flags", 16'h1, {14'h0, flag_l_n, flag_r_n});
				check("conf", 16'h1, n_conf[15:0]);
				check("held", {8'h00, w ? 8'h11 : 8'hC3}, {8'h00, ram_u.mem[11'h00C]});
				right(1'b1, 1'b1, 11'h000, 8'h00);
			end
		join
		if (w)
			check("wmem", 16'h003C, {8'h00, ram_u.mem[11'h00C]});
		else
			check("rconf", 16'h00C3, {8'h00, o_rdata});
	endtask

	always @(posedge i_clk) begin
		cyc++;
		if (o_conflict === 1'b1)
			n_conf++;
		if (cyc > 3000) begin
			n_fail++;
			stop_test();
		end
	end

	initial begin
		n_fail = 0;
		samples_checked = 0;
		cyc = 0;
		n_conf = 0;
		i_rst = 1'b1;
		i_req_valid = 1'b0;
		i_req = '0;
		right(1'b1, 1'b1, 11'h000, 8'h00);
		repeat (4) @(posedge i_clk);
		#1;
		i_rst = 1'b0;
		t_rw();
		t_conflict(1'b1);
		t_conflict(1'b0);
		stop_test();
	end
endmodule

// ---- testbench/dpc_ram_model.sv ----
// behavioural dual-port RAM, master variant; left port faces the controller
// assumes the bench drives the right port and reads flags as pulled-up levels
`timescale 1ns/100ps

module dpc_ram_model (
	input  wire dpc_pkg::dpc_pins_t i_l_pins,
	input  wire logic               i_r_sel_n,
	input  wire logic               i_r_we_n,
	input  wire logic [10:0]        i_r_addr,
	input  wire logic [7:0]         i_r_data,
	output logic [7:0]              o_l_data,
	output logic                    o_l_flag_n,
	output logic                    o_r_flag_n
);
	logic [7:0] mem [0:2047];
	logic [7:0] last;
	realtime    t_l;
	realtime    t_r;
	logic       hit;
	logic       l_rd;

	initial last = 8'h00;
	always @(i_l_pins.sel_n, i_l_pins.addr) t_l = $realtime;
	always @(i_r_sel_n, i_r_addr) t_r = $realtime;
	assign hit = !i_l_pins.sel_n && !i_r_sel_n && i_l_pins.addr == i_r_addr;
	assign #10 o_l_flag_n = !(hit && t_l >= t_r);
	assign #10 o_r_flag_n = !(hit && t_l < t_r);
	always @(i_l_pins, o_l_flag_n) begin
		if (!i_l_pins.sel_n && !i_l_pins.we_n && o_l_flag_n === 1'b1)
			mem[i_l_pins.addr] = i_l_pins.data;
	end
	always @(i_r_sel_n, i_r_we_n, i_r_addr, i_r_data, o_r_flag_n) begin
		if (!i_r_sel_n && !i_r_we_n && o_r_flag_n === 1'b1)
			mem[i_r_addr] = i_r_data;
	end
	assign l_rd = !i_l_pins.sel_n && i_l_pins.we_n && !i_l_pins.oe_n;
	always @(negedge l_rd) last = mem[i_l_pins.addr];
	assign #15 o_l_data = i_l_pins.data_oe ? i_l_pins.data : l_rd ? mem[i_l_pins.addr] : ~last;
endmodule
